/* File: addr_mode_pkg.sv */
/*
 * Shared types and constants for the operand address generator.
 * Assumes a byte-wide memory port with a one-cycle read latency.
 */
package addr_mode_pkg;

	// Seventeen addressing modes, grouped into seven families.
	typedef enum logic [4:0] {
		am_inherent,
		am_immediate,
		am_dir_short,
		am_dir_long,
		am_idx_none,
		am_idx_short,
		am_idx_long,
		am_ind_short,
		am_ind_long,
		am_indidx_short,
		am_indidx_long,
		am_rel_dir,
		am_rel_ind,
		am_bit_dir,
		am_bit_ind,
		am_bitrel_dir,
		am_bitrel_ind
	} mode_type;

	// Mode count and width of the operand space.
	localparam int MODE_COUNT = 17;
	localparam int ADDR_W     = 16;
	localparam logic [7:0] MASK_LEVEL_SET   = 8'h03;
	localparam logic [7:0] MASK_LEVEL_CLEAR = 8'h00;

	// Decoded request handed to the address engine.
	typedef struct packed {
		mode_type   mode;
		logic       use_y;
		logic       rmw;
		logic       mask_set_op;
		logic       mask_clear_op;
	} request_type;

	// Result of one address calculation.
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  imm;
		logic        is_imm;
		logic        is_branch;
		logic [15:0] target;
		logic [2:0]  length;
		logic        illegal;
	} result_type;

endpackage

/* File: ea_adder.sv */
/*
 * Unsigned effective-address adder for indexed forms.
 * Assumes both inputs are stable in the same cycle; purely combinational.
 */
`timescale 1ns/1ns
module ea_adder #(
	parameter int BASE_W = 16
) (
	input  wire logic [BASE_W-1:0] i_base,
	input  wire logic [7:0]        i_index,
	input  wire logic              i_en,
	output logic      [15:0]       o_sum
);
	// Zero-extended sum; a short base plus index can reach 1fe.
	wire [16:0] wide_sum;

	// The sum is only defined for bases of one byte up to one word.
	if (BASE_W < 8 || BASE_W > 16) begin : g_bad_width
		$error("ea_adder: BASE_W must be 8..16");
	end

	assign wide_sum = {1'b0, 16'(i_base)} + {9'h000, i_index};
	assign o_sum    = i_en ? wide_sum[15:0] : 16'(i_base);
endmodule

/* File: operand_addr.sv */
/*
 * Operand address generator of the 8-bit core: counts the bytes after
 * the opcode, fetches pointers and forms the effective address.
 * Assumes memory returns i_mem_data one cycle after o_mem_rd.
 */
`timescale 1ns/1ns
// Functional notes
// RULE_01: Seventeen modes in seven groups supported.
// RULE_02: Inherent is one byte, no fetch.
// RULE_03: Immediate second byte is the operand.
// RULE_04: Short direct uses one address byte.
// RULE_05: Long direct fetches a two-byte address.
// RULE_06: Indexed adds index to offset unsigned.
// RULE_07: No-offset indexed uses index alone.
// RULE_08: Short indexed reaches up to 1fe.
// RULE_09: Long indexed uses two-byte offset.
// RULE_10: Indirect byte addresses a memory pointer.
// RULE_11: Short indirect pointer is one byte.
// RULE_12: Long indirect pointer is one word.
// RULE_13: Long variants reach whole 64 Kbyte.
// RULE_14: Short variants stay in page zero; short indexed sums here reach up to 1fe.
// RULE_15: Read-modify-write accepts short forms only.
// RULE_16: Mask set gives 3, clear 0.
// RULE_17: Relative adds signed byte to counter.
// RULE_18: Indirect indexed adds index to pointer.
// RULE_19: Index sums zero-extend, no page wrap.
module operand_addr (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_nrst,
	input  wire logic                       i_start,
	input  wire addr_mode_pkg::request_type i_req,
	input  wire logic [15:0]                i_pc,
	input  wire logic [7:0]                 i_x,
	input  wire logic [7:0]                 i_y,
	input  wire logic [7:0]                 i_mem_data,
	output logic                            o_busy,
	output logic                            o_mem_rd,
	output logic [15:0]                     o_mem_addr,
	output logic                            o_done,
	output addr_mode_pkg::result_type       o_result,
	output logic [7:0]                      o_mask_level
);
	// Engine steps: operand bytes, then pointer bytes, then finish.
	typedef enum logic [2:0] {
		st_idle,
		st_op1,
		st_op2,
		st_ptr1,
		st_ptr2,
		st_done
	} state_type;

	state_type                  state;
	state_type                  next_state;
	addr_mode_pkg::request_type req;      // Latched request.
	logic [15:0]                pc_ptr;   // Next instruction byte.
	logic [7:0]                 b1;       // First byte after opcode.
	logic [15:0]                word;     // Address, offset or pointer.
	logic [7:0]                 index;    // Selected index register.
	logic [2:0]                 length;   // Bytes after the opcode.
	logic                       settle;   // Second cycle in st_done.

	// Decode of the latched mode into fetch needs.
	wire addr_mode_pkg::mode_type m = req.mode;
	// RULE_02: inherent modes and no-offset index fetch nothing.
	wire need_op1  = m != addr_mode_pkg::am_inherent &&
	                 m != addr_mode_pkg::am_idx_none;
	// RULE_05: long direct and RULE_09 long indexed take a word.
	wire need_op2  = m == addr_mode_pkg::am_dir_long ||
	                 m == addr_mode_pkg::am_idx_long;
	// RULE_10: indirect forms read a pointer in page zero.
	wire is_ind    = m == addr_mode_pkg::am_ind_short ||
	                 m == addr_mode_pkg::am_ind_long ||
	                 m == addr_mode_pkg::am_indidx_short ||
	                 m == addr_mode_pkg::am_indidx_long ||
	                 m == addr_mode_pkg::am_rel_ind ||
	                 m == addr_mode_pkg::am_bit_ind ||
	                 m == addr_mode_pkg::am_bitrel_ind;
	// RULE_12: long pointers are two bytes, high byte first.
	wire ptr_word  = m == addr_mode_pkg::am_ind_long ||
	                 m == addr_mode_pkg::am_indidx_long;
	// RULE_06: indexed families add the index register.
	wire use_idx   = m == addr_mode_pkg::am_idx_none ||
	                 m == addr_mode_pkg::am_idx_short ||
	                 m == addr_mode_pkg::am_idx_long ||
	                 m == addr_mode_pkg::am_indidx_short ||
	                 m == addr_mode_pkg::am_indidx_long;
	wire is_rel    = m == addr_mode_pkg::am_rel_dir ||
	                 m == addr_mode_pkg::am_rel_ind;
	// Bit-relative forms carry a trailing displacement byte.
	wire is_bitrel = m == addr_mode_pkg::am_bitrel_dir ||
	                 m == addr_mode_pkg::am_bitrel_ind;
	// RULE_15: long forms are illegal on read-modify-write opcodes.
	wire is_long   = need_op2 || ptr_word;
	wire illegal   = req.rmw && is_long;

	// Select the index register requested by the decoder.
	assign index = req.use_y ? i_y : i_x;

	// RULE_07: no-offset base is zero, sum is the index alone.
	wire [15:0] base = (m == addr_mode_pkg::am_idx_none) ? 16'h0000 : word;
	wire [15:0] ea;

	// RULE_18: the adder also serves indirect indexed pointers.
	// RULE_19: zero-extended add, short sums may reach 1fe.
	ea_adder #(
		.BASE_W (16)
	) u_adder (
		.i_base  (base),
		.i_index (index),
		.i_en    (use_idx),
		.o_sum   (ea)
	);

	// RULE_17: signed byte displacement added to the counter.
	wire [7:0]  disp   = (m == addr_mode_pkg::am_rel_ind) ? word[7:0] : b1;
	wire [15:0] target = pc_ptr + {{8{disp[7]}}, disp};

	// Next-state logic of the fetch engine.
	always_comb begin
		next_state = state;
		case (state)
			st_idle: begin
				if (i_start)
					next_state = st_op1;
			end
			st_op1: begin
				if (!need_op1)
					next_state = st_done;
				else if (need_op2)
					next_state = st_op2;
				else if (is_ind)
					next_state = st_ptr1;
				else
					next_state = st_done;
			end
			st_op2: begin
				next_state = st_done;
			end
			st_ptr1: begin
				next_state = ptr_word ? st_ptr2 : st_done;
			end
			st_ptr2: begin
				next_state = st_done;
			end
			// The last byte lands one cycle late, so hold for settle.
			st_done: begin
				next_state = settle ? st_idle : st_done;
			end
			default: begin
				next_state = st_idle;
			end
		endcase
	end

	// Memory port: instruction bytes from pc_ptr, pointers from ptr_base (data bus in st_ptr1, b1 in st_ptr2).
	wire rd_op  = (state == st_op1 && need_op1) || state == st_op2;
	wire rd_ptr = state == st_ptr1 || state == st_ptr2;
	// The pointer address byte is still on the data bus in st_ptr1;
	// b1 only holds it one edge later, in time for st_ptr2.
	wire [7:0] ptr_base = (state == st_ptr1) ? i_mem_data : b1;
	assign o_mem_rd   = rd_op || rd_ptr;
	// RULE_11: the pointer address is a page-zero byte.
	assign o_mem_addr = rd_ptr ?
	                    {8'h00,
	                     ptr_base + ((state == st_ptr2) ? 8'h01 : 8'h00)} :
	                    pc_ptr;
	assign o_busy     = state != st_idle;

	// The engine state and latched request.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			state <= st_idle;
			req   <= '0;
		end else begin
			state <= next_state;
			if (state == st_idle && i_start)
				req <= i_req;
		end
	end

	// Data capture; read data arrive one cycle after the strobe.
	logic rd_op_q;
	logic rd_ptr_q;
	logic [1:0] phase_q;
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			rd_op_q  <= 1'b0;
			rd_ptr_q <= 1'b0;
			phase_q  <= 2'h0;
		end else begin
			rd_op_q  <= rd_op;
			rd_ptr_q <= rd_ptr;
			phase_q  <= (state == st_op2 || state == st_ptr2) ? 2'h2 :
			            2'h1;
		end
	end

	// Operand and pointer registers.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			pc_ptr <= 16'h0000;
			b1     <= 8'h00;
			word   <= 16'h0000;
			length <= 3'h0;
		end else if (state == st_idle && i_start) begin
			pc_ptr <= i_pc;
			word   <= 16'h0000;
			length <= 3'h0;
		end else begin
			if (rd_op) begin
				pc_ptr <= pc_ptr + 16'h0001;
				length <= length + 3'h1;
			end
			if (rd_op_q && phase_q == 2'h1) begin
				// RULE_04: one byte lands in page zero.
				b1   <= i_mem_data;
				word <= {8'h00, i_mem_data};
			end
			// RULE_05: second byte is the low half of a word.
			if (rd_op_q && phase_q == 2'h2)
				word <= {word[7:0], i_mem_data};
			if (rd_ptr_q && phase_q == 2'h1)
				word <= {8'h00, i_mem_data};
			if (rd_ptr_q && phase_q == 2'h2)
				word <= {word[7:0], i_mem_data};
		end
	end

	// The last captured byte lands one cycle after the final read,
	// so completion waits on a settle cycle in st_done.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			settle <= 1'b0;
		else
			settle <= state == st_done && !settle;
	end
	wire finish = state == st_done && settle;

	// Result register and mask level.
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_done       <= 1'b0;
			o_result     <= '0;
			o_mask_level <= addr_mode_pkg::MASK_LEVEL_CLEAR;
		end else begin
			o_done <= finish;
			if (finish) begin
				// RULE_03: immediate byte is the operand itself.
				o_result.is_imm    <= m == addr_mode_pkg::am_immediate;
				o_result.imm       <= b1;
				// RULE_13: long results span the full 16 bits.
				// RULE_14: short results come from a byte.
				o_result.addr      <= ea;
				o_result.is_branch <= is_rel;
				o_result.target    <= target;
				o_result.length    <= length + (is_bitrel ? 3'h1 : 3'h0);
				o_result.illegal   <= illegal;
			end
			// RULE_16: inherent mask ops load fixed levels.
			if (finish && m == addr_mode_pkg::am_inherent) begin
				if (req.mask_set_op)
					o_mask_level <= addr_mode_pkg::MASK_LEVEL_SET;
				else if (req.mask_clear_op)
					o_mask_level <= addr_mode_pkg::MASK_LEVEL_CLEAR;
			end
		end
	end

	// Engine leaves st_done only after the settle cycle.
	// (The state machine's st_done branch returns to idle once settle is set.)

	// RULE_01: every legal mode value decodes to a group.
	chk_mode_range: assert property (@(posedge i_clk_sys) // RULE_01
		disable iff (!i_nrst)
		o_busy |-> int'(req.mode) < addr_mode_pkg::MODE_COUNT)
		else $error("mode code out of range");

	chk_inh_nofetch: assert property (@(posedge i_clk_sys) // RULE_02
		disable iff (!i_nrst)
		(o_busy && m == addr_mode_pkg::am_inherent) |-> !o_mem_rd)
		else $error("inherent mode fetched a byte");

	chk_mask_set: assert property (@(posedge i_clk_sys) // RULE_16
		disable iff (!i_nrst)
		(finish && m == addr_mode_pkg::am_inherent && req.mask_set_op)
		|=> o_mask_level == 8'h03)
		else $error("mask set did not give level 3");

	chk_ind_page0: assert property (@(posedge i_clk_sys) // RULE_11
		disable iff (!i_nrst)
		rd_ptr |-> o_mem_addr[15:8] == 8'h00)
		else $error("pointer read left page zero");

	chk_short_range: assert property (@(posedge i_clk_sys) // RULE_08
		disable iff (!i_nrst)
		(finish && m == addr_mode_pkg::am_idx_short)
		|=> o_result.addr <= 16'h01fe)
		else $error("short indexed sum above 1fe");

	chk_rmw_long: assert property (@(posedge i_clk_sys) // RULE_15
		disable iff (!i_nrst)
		(finish && req.rmw && need_op2) |=> o_result.illegal)
		else $error("long form on rmw not flagged");

	chk_done_pulse: assert property (@(posedge i_clk_sys) // RULE_10
		disable iff (!i_nrst)
		(state == st_ptr1) |-> ##[1:4] finish)
		else $error("pointer fetch did not complete");

	chk_imm_len: assert property (@(posedge i_clk_sys) // RULE_03
		disable iff (!i_nrst)
		(finish && m == addr_mode_pkg::am_immediate)
		|=> o_result.length == 3'h1)
		else $error("immediate not two bytes");
endmodule

/* File: mem_model.sv */
/*
 * Behavioural program and data memory for the address generator.
 * Assumes reads are strobed for one cycle and answered one cycle later.
 */
`timescale 1ns/1ns
module mem_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_addr,
	output logic      [7:0]  o_data
);
	// Byte store, filled by the bench before the operations that read it.
	logic [7:0] m [0:65535];
	// Strobes seen since the bench last cleared the count.
	int         n_reads = 0;

	initial o_data = 8'h5a;

	// Answer one cycle after the strobe. With no strobe the bus toggles,
	// so a sample one cycle late reads the complement of the good data.
	always @(posedge i_clk_sys) begin
		if (i_rd) begin
			o_data  <= m[i_addr];
			n_reads <= n_reads + 1;
		end else begin
			o_data <= ~o_data;
		end
	end
endmodule

/* File: tb_cpu_operand_address_modes.sv */
/*
 * Self-checking bench for the operand address generator.
 * Assumes the memory model answers reads one cycle after the strobe.
 */
`timescale 1ns/1ns
module tb_cpu_operand_address_modes;
	logic                       clk = 1'b0;
	logic                       nrst = 1'b0;
	logic                       start = 1'b0;
	addr_mode_pkg::request_type req = '0;
	logic [15:0]                pc = 16'h0200;
	logic [7:0]                 x = 8'hff;
	logic [7:0]                 y = 8'hff;
	logic [7:0]                 mdata;
	logic                       busy, rd, done;
	logic [15:0]                maddr;
	addr_mode_pkg::result_type  res;
	logic [7:0]                 mask;
	int                         bad_count = 0;
	int                         n_checks = 0;

	always #5 clk = ~clk;

	operand_addr uut (.i_clk_sys(clk), .i_nrst(nrst), .i_start(start),
		.i_req(req), .i_pc(pc), .i_x(x), .i_y(y), .i_mem_data(mdata),
		.o_busy(busy), .o_mem_rd(rd), .o_mem_addr(maddr), .o_done(done),
		.o_result(res), .o_mask_level(mask));
	mem_model mem (.i_clk_sys(clk), .i_rd(rd), .i_addr(maddr),
		.o_data(mdata));

	// Compare one value and count it.
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Print counts and the verdict, then stop.
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Launch one operation and wait, bounded, for its done pulse.
	task automatic run(input addr_mode_pkg::mode_type md,
		input logic uy, rmw, ms, mc);
		int k;
		@(negedge clk);
		req = '{mode:md, use_y:uy, rmw:rmw, mask_set_op:ms,
			mask_clear_op:mc};
		mem.n_reads = 0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		chk("busy", busy, 1);
		k = 0;
		while (done !== 1'b1 && k < 40) begin
			@(negedge clk);
			k++;
		end
		if (k == 40) chk("done", 0, 1);
	endtask

	// Address, length and read count of one finished operation.
	task automatic ea(input logic [15:0] a, input int len, nrd);
		chk("addr", res.addr, a);
		chk("length", res.length, len);
		chk("reads", mem.n_reads, nrd);
	endtask

	// Outputs stay quiet across reset.
	task automatic t_reset();
		chk("rst", {busy, rd, done, mask}, 0);
		chk("rst_res", res[31:0], 0);
	endtask

	// No fetch at all; mask levels 3 and 0.
	task automatic t_inherent();
		run(addr_mode_pkg::am_inherent, 0, 0, 1, 0);
		chk("len", res.length, 0);
		chk("rd", mem.n_reads, 0);
		chk("mask", mask, 8'h03);
		run(addr_mode_pkg::am_inherent, 0, 0, 0, 1);
		chk("mask", mask, 8'h00);
	endtask

	// The byte after the opcode is the operand itself.
	task automatic t_immediate();
		mem.m[16'h0200] = 8'h55;
		run(addr_mode_pkg::am_immediate, 0, 0, 0, 0);
		chk("imm", {res.is_imm, res.imm}, 9'h155);
		chk("len", res.length, 1);
	endtask

	// Short, long and bit direct, high byte first.
	task automatic t_direct();
		mem.m[16'h0200] = 8'hab;
		mem.m[16'h0201] = 8'hcd;
		run(addr_mode_pkg::am_dir_short, 0, 0, 0, 0);
		ea(16'h00ab, 1, 1);
		run(addr_mode_pkg::am_dir_long, 0, 0, 0, 0);
		ea(16'habcd, 2, 2);
		run(addr_mode_pkg::am_bit_dir, 0, 0, 0, 0);
		chk("bit", res.addr, 16'h00ab);
	endtask

	// Indexed sums with the widest byte values.
	task automatic t_indexed();
		mem.m[16'h0200] = 8'hff;
		run(addr_mode_pkg::am_idx_none, 0, 0, 0, 0);
		ea(16'h00ff, 0, 0);
		run(addr_mode_pkg::am_idx_short, 0, 0, 0, 0);
		ea(16'h01fe, 1, 1);
		y = 8'h01;
		run(addr_mode_pkg::am_idx_short, 1, 0, 0, 0);
		chk("y", res.addr, 16'h0100);
		mem.m[16'h0200] = 8'h12;
		mem.m[16'h0201] = 8'h34;
		run(addr_mode_pkg::am_idx_long, 0, 0, 0, 0);
		ea(16'h1333, 2, 2);
		y = 8'hff;
	endtask

	// Pointer fetched from page zero, then indexed.
	task automatic t_indirect();
		mem.m[16'h0200] = 8'h40;
		mem.m[16'h0040] = 8'h9a;
		mem.m[16'h0041] = 8'hbc;
		run(addr_mode_pkg::am_ind_short, 0, 0, 0, 0);
		ea(16'h009a, 1, 2);
		run(addr_mode_pkg::am_ind_long, 0, 0, 0, 0);
		ea(16'h9abc, 1, 3);
		run(addr_mode_pkg::am_indidx_short, 1, 0, 0, 0);
		chk("iis", res.addr, 16'h0199);
		run(addr_mode_pkg::am_indidx_long, 0, 0, 0, 0);
		chk("iil", res.addr, 16'h9bbb);
		run(addr_mode_pkg::am_bit_ind, 0, 0, 0, 0);
		chk("bi", res.addr, 16'h009a);
	endtask

	// Signed displacement, direct and through memory.
	task automatic t_relative();
		mem.m[16'h0200] = 8'h80;
		run(addr_mode_pkg::am_rel_dir, 0, 0, 0, 0);
		chk("br", {res.is_branch, res.target}, 17'h10181);
		mem.m[16'h0200] = 8'h40;
		mem.m[16'h0040] = 8'h05;
		run(addr_mode_pkg::am_rel_ind, 0, 0, 0, 0);
		chk("bri", res.target, 16'h0206);
	endtask

	// Read-modify-write refuses the long form only.
	task automatic t_rmw();
		run(addr_mode_pkg::am_dir_long, 0, 1, 0, 0);
		chk("ill", res.illegal, 1);
		run(addr_mode_pkg::am_dir_short, 0, 1, 0, 0);
		chk("ok", res.illegal, 0);
	endtask

	// Main sequence: reset for six cycles, then every scenario.
	initial begin
		repeat (6) @(negedge clk);
		t_reset();
		nrst = 1'b1;
		t_inherent();
		t_immediate();
		t_direct();
		t_indexed();
		t_indirect();
		t_relative();
		t_rmw();
		summarize();
	end

	// 19 operations of under 50 cycles each; far beyond is a hang.
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
endmodule
